// ==== core/ipe_defines.svh ====
// Offsets, field positions, reset values for the interrupt priority/enable block
`ifndef IPE_DEFINES_SVH
`define IPE_DEFINES_SVH
`define IPE_ADDR_W 8
`define IPE_OFF_PSW 8'h00
`define IPE_OFF_EN3 8'h04
`define IPE_OFF_PR3 8'h08
`define IPE_OFF_PR5 8'h0c
`define IPE_OFF_CTL 8'h10
`define IPE_OFF_STAT 8'h14
`define IPE_OFF_MASK 8'h18
`define IPE_PSW_LVL_LO 5
`define IPE_EN_CAL_BIT 14
`define IPE_EN_BM_BIT 2
`define IPE_EN_BS_BIT 1
`define IPE_PR_MEM_LO 12
`define IPE_PR_CONV_LO 4
`define IPE_PR_SER_LO 0
`define IPE_PR_EXT1_LO 0
`define IPE_CTL_EXT_BIT 3
`define IPE_CTL_NEST_BIT 15
`define IPE_PRIO_RST 3'h4
`define IPE_EN_RST 3'h0
`define IPE_LVL_RST 3'h0
`define IPE_NSRC 7
`endif

// ==== core/ipe_pkg.sv ====
// Types shared by the interrupt priority/enable block
package ipe_pkg;
  typedef logic [2:0] ipe_prio_t;
  typedef logic [6:0] ipe_src_t;
  typedef enum logic [1:0] {
    ipe_st_idle = 2'b01,
    ipe_st_offer = 2'b10
  } ipe_state_e;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic hready;
    logic hresp;
    ipe_prio_t lvl;
    logic ext;
    logic nest;
    logic [2:0] en3;
    logic [3:0][2:0] prio;
    ipe_src_t status;
    ipe_src_t mask;
    ipe_state_e state;
    logic core_req;
    logic [2:0] core_idx;
    ipe_prio_t core_prio;
    logic [3:0] cpu_level;
    logic irq;
  } ipe_state_s;
endpackage : ipe_pkg

// ==== core/ipe_arb_if.sv ====
// Carrier between register/control logic and the priority arbiter
`timescale 1ns/1ps
interface ipe_arb_if #(
  parameter int NSRC = 7
);
  logic [NSRC-1:0] cand;
  logic [NSRC*3-1:0] prio;
  logic [3:0] level;
  logic win_valid;
  logic [2:0] win_idx;
  logic [2:0] win_prio;
  modport arb (input cand, input prio, input level,
               output win_valid, output win_idx, output win_prio);
  modport ctl (output cand, output prio, output level,
               input win_valid, input win_idx, input win_prio);
endinterface : ipe_arb_if

// ==== core/ipe_arbiter.sv ====
// Picks the most urgent eligible source above the CPU level
`timescale 1ns/1ps
module ipe_arbiter #(
  parameter int NSRC = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  ipe_arb_if.arb arb
);
  logic [2:0] best_p;
  logic [2:0] best_i;
  logic best_v;
  logic [NSRC-1:0] hi7;

  // Strict compare keeps the lowest index on equal priority
  always_comb begin
    best_p = 3'h0;
    best_i = 3'h0;
    best_v = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (arb.cand[i] && (arb.prio[i*3 +: 3] != 3'h0)
          && ({1'b0, arb.prio[i*3 +: 3]} > arb.level)
          && (arb.prio[i*3 +: 3] > best_p)) begin
        best_p = arb.prio[i*3 +: 3];
        best_i = i[2:0];
        best_v = 1'b1;
      end
    end
  end

  assign arb.win_valid = best_v;
  assign arb.win_idx = best_i;
  assign arb.win_prio = best_p;

  // Candidates at the top code, for checking only
  for (genvar g = 0; g < NSRC; g++) begin : g_hi
    assign hi7[g] = arb.cand[g] && (arb.prio[g*3 +: 3] == 3'h7);
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  win_above_level_a: assert property (
    arb.win_valid |-> ({1'b0, arb.win_prio} > arb.level))
    else $error("winner not above cpu level");
  win_not_disabled_a: assert property (
    arb.win_valid |-> (arb.win_prio != 3'h0) && arb.cand[arb.win_idx])
    else $error("disabled or absent source won");
  top_code_wins_a: assert property (
    ((|hi7) && (arb.level < 4'h7)) |-> arb.win_valid && (arb.win_prio == 3'h7))
    else $error("code 111 did not win");
  ext_blocks_all_a: assert property (
    arb.level[3] |-> !arb.win_valid)
    else $error("request passed an extended level");
endmodule : ipe_arbiter

// ==== core/ipe_top.sv ====
// Interrupt enable/priority registers, CPU level and request forwarding
// Operation
// - Three-bit priority codes: 111 most urgent, down to 001 least urgent.
// - Priority code 000 disables the source; it never reaches the core.
// - Three-bit CPU level in status word, software and hardware can update it.
// - Effective level is extension bit above three-bit field; extension adds eight.
// - External line one priority in bits 2-0, resets to 100, upper bits absent.
// - Enable register: calendar bit 14, master bit 2, slave bit 1, reset 0.
// - Priority register: memory 14-12, conversion 6-4, transmit 2-0, reset 100.
// - Unimplemented bits read as zero and ignore writes.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ipe_defines.svh"
module ipe_top #(
  parameter logic [2:0] FIXED_PRIO = `IPE_PRIO_RST
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [6:0] src_event,
  input wire logic core_ack,
  output logic core_req,
  output logic [2:0] core_idx,
  output logic [2:0] core_prio,
  output logic [3:0] cpu_level,
  output logic irq
);
  localparam ipe_pkg::ipe_state_s RST = '{
    sel: 1'b0,
    wr: 1'b0,
    addr: 8'h00,
    rdata: 32'h0000_0000,
    hready: 1'b1,
    hresp: 1'b0,
    lvl: `IPE_LVL_RST,
    ext: 1'b0,
    nest: 1'b0,
    en3: `IPE_EN_RST,
    prio: {4{`IPE_PRIO_RST}},
    status: 7'h00,
    mask: 7'h00,
    state: ipe_pkg::ipe_st_idle,
    core_req: 1'b0,
    core_idx: 3'h0,
    core_prio: 3'h0,
    cpu_level: 4'h0,
    irq: 1'b0
  };

  ipe_pkg::ipe_state_s s;
  ipe_pkg::ipe_state_s n;
  logic [15:0] wdat;
  logic [6:0] w1c;
  logic [6:0] ackclr;
  logic take;
  logic first_q;

  ipe_arb_if #(.NSRC(`IPE_NSRC)) arb ();

  // Register image of one word; absent bits stay zero
  function automatic logic [31:0] rd_word(input ipe_pkg::ipe_state_s st,
                                          input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == `IPE_OFF_PSW) begin
      r[`IPE_PSW_LVL_LO +: 3] = st.lvl;
    end else if (a == `IPE_OFF_EN3) begin
      r[`IPE_EN_CAL_BIT] = st.en3[2];
      r[`IPE_EN_BM_BIT] = st.en3[1];
      r[`IPE_EN_BS_BIT] = st.en3[0];
    end else if (a == `IPE_OFF_PR3) begin
      r[`IPE_PR_MEM_LO +: 3] = st.prio[0];
      r[`IPE_PR_CONV_LO +: 3] = st.prio[1];
      r[`IPE_PR_SER_LO +: 3] = st.prio[2];
    end else if (a == `IPE_OFF_PR5) begin
      r[`IPE_PR_EXT1_LO +: 3] = st.prio[3];
    end else if (a == `IPE_OFF_CTL) begin
      r[`IPE_CTL_EXT_BIT] = st.ext;
      r[`IPE_CTL_NEST_BIT] = st.nest;
    end else if (a == `IPE_OFF_STAT) begin
      r[6:0] = st.status;
    end else if (a == `IPE_OFF_MASK) begin
      r[6:0] = st.mask;
    end
    return r;
  endfunction : rd_word

  // Address phase accepted at this edge; shared by capture and read-data paths
  function automatic logic addr_taken(input logic sel_i, input logic [1:0] tr_i,
                                      input logic rdy_i);
    return sel_i && tr_i[1] && rdy_i;
  endfunction : addr_taken

  // Arbiter sees registered state only, so its answer is stable all cycle
  // Status runs calendar, master, slave upward from bit 4; enable bits run the other way
  assign arb.cand = s.status & {s.en3[0], s.en3[1], s.en3[2], 4'hf};
  assign arb.prio = {FIXED_PRIO, FIXED_PRIO, FIXED_PRIO,
                     s.prio[3], s.prio[2], s.prio[1], s.prio[0]};
  assign arb.level = {s.ext, s.lvl};

  ipe_arbiter #(.NSRC(`IPE_NSRC)) u_arb (
    .hclk(hclk),
    .hresetn(hresetn),
    .arb(arb)
  );

  // Next state: bus write, forwarding handshake, flags, bus read
  always_comb begin
    n = s;
    wdat = hwdata[15:0];
    w1c = 7'h00;
    ackclr = 7'h00;
    take = 1'b0;
    // Data phase write; unimplemented bits simply not stored
    if (s.sel && s.wr) begin
      if (s.addr == `IPE_OFF_PSW) begin
        if (!s.nest) begin
          n.lvl = wdat[`IPE_PSW_LVL_LO +: 3];
        end
      end else if (s.addr == `IPE_OFF_EN3) begin
        n.en3 = {wdat[`IPE_EN_CAL_BIT], wdat[`IPE_EN_BM_BIT],
                 wdat[`IPE_EN_BS_BIT]};
      end else if (s.addr == `IPE_OFF_PR3) begin
        n.prio[0] = wdat[`IPE_PR_MEM_LO +: 3];
        n.prio[1] = wdat[`IPE_PR_CONV_LO +: 3];
        n.prio[2] = wdat[`IPE_PR_SER_LO +: 3];
      end else if (s.addr == `IPE_OFF_PR5) begin
        n.prio[3] = wdat[`IPE_PR_EXT1_LO +: 3];
      end else if (s.addr == `IPE_OFF_CTL) begin
        n.ext = wdat[`IPE_CTL_EXT_BIT];
        n.nest = wdat[`IPE_CTL_NEST_BIT];
      end else if (s.addr == `IPE_OFF_STAT) begin
        w1c = wdat[6:0];
      end else if (s.addr == `IPE_OFF_MASK) begin
        n.mask = wdat[6:0];
      end
    end
    // Offer to the core; withdrawn if no longer eligible
    case (s.state)
      ipe_pkg::ipe_st_idle: begin
        if (arb.win_valid) begin
          n.state = ipe_pkg::ipe_st_offer;
          n.core_req = 1'b1;
          n.core_idx = arb.win_idx;
          n.core_prio = arb.win_prio;
        end
      end
      ipe_pkg::ipe_st_offer: begin
        if (core_ack) begin
          take = 1'b1;
          n.state = ipe_pkg::ipe_st_idle;
          n.core_req = 1'b0;
          n.lvl = s.core_prio;
          ackclr[s.core_idx] = 1'b1;
        end else if (!arb.win_valid || (arb.win_idx != s.core_idx)) begin
          n.state = ipe_pkg::ipe_st_idle;
          n.core_req = 1'b0;
        end
      end
      default: begin
        n.state = ipe_pkg::ipe_st_idle;
        n.core_req = 1'b0;
      end
    endcase
    // A new event beats a clear landing in the same cycle
    n.status = (s.status & ~w1c & ~ackclr) | src_event;
    n.irq = |(n.status & n.mask);
    n.cpu_level = {n.ext, n.lvl};
    // Address phase; read data sees this cycle's write already
    n.sel = addr_taken(hsel, htrans, hready);
    n.wr = hwrite;
    n.addr = haddr[7:0];
    if (addr_taken(hsel, htrans, hready) && !hwrite) begin
      n.rdata = rd_word(n, haddr[7:0]);
    end
    n.hready = 1'b1;
    n.hresp = 1'b0;
  end

  // Single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= RST;
    end else begin
      s <= n;
    end
  end

  // Marks the first edge after reset release, for checks only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  assign hreadyout = s.hready;
  assign hresp = s.hresp;
  assign hrdata = s.rdata;
  assign core_req = s.core_req;
  assign core_idx = s.core_idx;
  assign core_prio = s.core_prio;
  assign cpu_level = s.cpu_level;
  assign irq = s.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  reset_prio_vals_a: assert property (
    first_q |-> (s.prio[0] == 3'h4) && (s.prio[1] == 3'h4) && (s.prio[2] == 3'h4))
    else $error("priority reset value wrong");
  reset_ext1_val_a: assert property (
    first_q |-> (s.prio[3] == 3'h4) && (s.en3 == 3'h0))
    else $error("line one priority or enable reset wrong");
  ext1_read_narrow_a: assert property (
    (hsel && htrans[1] && hready && !hwrite && (haddr[7:0] == `IPE_OFF_PR5))
    |=> (hrdata[31:3] == 29'h0) && (hrdata[2:0] == s.prio[3]))
    else $error("line one priority read wrong");
  en3_read_zero_a: assert property (
    (hsel && htrans[1] && hready && !hwrite && (haddr[7:0] == `IPE_OFF_EN3))
    |=> ((hrdata & ~32'h0000_4006) == 32'h0))
    else $error("unimplemented enable bits not zero");
  en3_write_map_a: assert property (
    (s.sel && s.wr && (s.addr == `IPE_OFF_EN3) && !take)
    |=> (s.en3 == {$past(hwdata[14]), $past(hwdata[2]), $past(hwdata[1])}))
    else $error("enable write not stored");
  level_on_ack_a: assert property (
    (s.core_req && core_ack && (s.state == ipe_pkg::ipe_st_offer))
    |=> (s.lvl == $past(s.core_prio)) && !s.core_req && (cpu_level[2:0] == s.lvl))
    else $error("cpu level not raised on accept");
  ext_level_a: assert property (
    s.ext |-> (cpu_level == {1'b1, s.lvl}) ##1 !core_req)
    else $error("extended level wrong or request leaked");
  offer_prio_a: assert property (
    $rose(core_req) |-> ({1'b0, core_prio} > $past(cpu_level)) && (core_prio != 3'h0))
    else $error("request offered at or below cpu level");
  event_beats_clear_a: assert property (
    (s.sel && s.wr && (s.addr == `IPE_OFF_STAT) && (|(hwdata[6:0] & src_event)))
    |=> ((s.status & $past(hwdata[6:0] & src_event)) == $past(hwdata[6:0] & src_event)))
    else $error("event lost to clear");
  irq_follows_a: assert property (
    ((|(src_event & s.mask)) && !(s.sel && s.wr && (s.addr == `IPE_OFF_MASK))) |=> irq)
    else $error("unmasked event without interrupt");
  ready_okay_a: assert property (
    hreadyout && !hresp)
    else $error("bus not ready or error response");

  // Priority words land field by field; reserved bits are dropped
  pr3_write_map_a: assert property (
    (s.sel && s.wr && (s.addr == `IPE_OFF_PR3))
    |=> (s.prio[0] == $past(hwdata[14:12])) && (s.prio[1] == $past(hwdata[6:4]))
        && (s.prio[2] == $past(hwdata[2:0])))
    else $error("priority group three write not stored");
  pr5_write_map_a: assert property (
    (s.sel && s.wr && (s.addr == `IPE_OFF_PR5)) |=> (s.prio[3] == $past(hwdata[2:0])))
    else $error("line one priority write not stored");

  // Nesting lock holds the level against software, not against an accept
  nest_locks_level_a: assert property (
    (s.sel && s.wr && (s.addr == `IPE_OFF_PSW) && s.nest && !take)
    |=> (s.lvl == $past(s.lvl)))
    else $error("level written while nesting locked");

  // Reads show only the implemented fields
  psw_read_narrow_a: assert property (
    (hsel && htrans[1] && hready && !hwrite && (haddr[7:0] == `IPE_OFF_PSW))
    |=> ((hrdata & ~32'h0000_00e0) == 32'h0) && (hrdata[7:5] == s.lvl))
    else $error("status word read wrong");
  pr3_read_zero_a: assert property (
    (hsel && htrans[1] && hready && !hwrite && (haddr[7:0] == `IPE_OFF_PR3))
    |=> ((hrdata & ~32'h0000_7077) == 32'h0))
    else $error("unimplemented priority bits not zero");

  // Writing ones clears flags, except where an event arrives that cycle
  w1c_clears_a: assert property (
    (s.sel && s.wr && (s.addr == `IPE_OFF_STAT))
    |=> ((s.status & $past(hwdata[6:0] & ~src_event)) == 7'h00))
    else $error("status bit not cleared by write");

  // Outputs at rest on the first edge after reset
  reset_outputs_a: assert property (
    first_q |-> !core_req && !irq && (cpu_level == 4'h0) && (hrdata == 32'h0))
    else $error("outputs not at rest after reset");

  // A vanished winner must not leave a stale offer standing
  offer_withdraw_a: assert property (
    ((s.state == ipe_pkg::ipe_st_offer) && !core_ack && !arb.win_valid) |=> !core_req)
    else $error("offer kept without an eligible winner");
  cal_gate_a: assert property (
    (s.status[4] && !s.en3[2]) |-> !(arb.win_valid && (arb.win_idx == 3'h4)))
    else $error("calendar request passed a clear enable");

  offer_taken_c: cover property (core_req && core_ack);
  irq_raised_c: cover property ($rose(irq));
  flag_cleared_c: cover property (s.sel && s.wr && (s.addr == `IPE_OFF_STAT) ##1 !irq);
  offer_withdrawn_c: cover property (core_req ##1 !core_req && !$past(core_ack));
endmodule : ipe_top

// ==== verif/ipe_core_model.sv ====
// Behavioural core that accepts offered interrupt requests after a chosen delay
`timescale 1ns/1ps
module ipe_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic core_req,
  input wire logic [1:0] delay,
  output logic core_ack
);
  logic [1:0] wait_q;
  // Ack is a single pulse; the count restarts so a slow core can be mimicked
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 2'h0;
      core_ack <= 1'b0;
    end else if (core_req && !core_ack && wait_q == delay) begin
      core_ack <= 1'b1;
      wait_q <= 2'h0;
    end else begin
      core_ack <= 1'b0;
      wait_q <= (core_req && !core_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule : ipe_core_model

// ==== verif/ipe_top_bench.sv ====
// Self-checking bench for the interrupt priority/enable block
`timescale 1ns/1ps
`include "ipe_defines.svh"
module ipe_top_bench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, core_ack;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0, dly = 2'h0;
  logic [2:0] hsize = 3'h2, core_idx, core_prio;
  logic [6:0] src_event = 7'h0;
  logic hreadyout, hresp, core_req, irq;
  logic [3:0] cpu_level;
  logic [2:0] acc_idx, acc_prio;
  int err_count = 0, total_checks = 0, cyc = 0, acc_n = 0, seed = 32'h73d7;
  int m_lvl, m_ext, m_nest, m_en, m_st, m_mk, n0, lv, go;
  int m_p[4];
  logic [7:0] offs[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h40};
  ipe_top i_ipe_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_event(src_event),
    .core_ack(core_ack), .core_req(core_req), .core_idx(core_idx), .core_prio(core_prio),
    .cpu_level(cpu_level), .irq(irq));
  ipe_core_model i_ipe_core_model (.hclk(hclk), .hresetn(hresetn), .core_req(core_req),
    .delay(dly), .core_ack(core_ack));
  always #25 hclk = ~hclk;
  // Record every accepted offer as the core sees it
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (core_req === 1'b1 && core_ack === 1'b1) begin
      acc_n <= acc_n + 1;
      acc_idx <= core_idx;
      acc_prio <= core_prio;
    end
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Reference register image; unimplemented bits never stored
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      `IPE_OFF_PSW: return 32'(m_lvl << 5);
      `IPE_OFF_EN3: return 32'(m_en);
      `IPE_OFF_PR3: return 32'((m_p[0] << 12) | (m_p[1] << 4) | m_p[2]);
      `IPE_OFF_PR5: return 32'(m_p[3]);
      `IPE_OFF_CTL: return 32'((m_ext << 3) | (m_nest << 15));
      `IPE_OFF_STAT: return 32'(m_st);
      `IPE_OFF_MASK: return 32'(m_mk);
      default: return 32'h0;
    endcase
  endfunction : exp_rd
  function automatic void mdl_wr(input logic [7:0] a, input int d);
    case (a)
      `IPE_OFF_PSW: if (m_nest == 0) m_lvl = (d >> 5) & 7;
      `IPE_OFF_EN3: m_en = d & 32'h4006;
      `IPE_OFF_PR3: begin
        m_p[0] = (d >> 12) & 7;
        m_p[1] = (d >> 4) & 7;
        m_p[2] = d & 7;
      end
      `IPE_OFF_PR5: m_p[3] = d & 7;
      `IPE_OFF_CTL: begin
        m_ext = (d >> 3) & 1;
        m_nest = (d >> 15) & 1;
      end
      `IPE_OFF_STAT: m_st = m_st & ~d;
      `IPE_OFF_MASK: m_mk = d & 32'h7f;
      default: ;
    endcase
  endfunction : mdl_wr
  // One single AHB transfer; hready and read data are taken at the rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
    if (w) mdl_wr(a, int'(d));
    else chk(r, exp_rd(a));
    chk({31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic ev(input int b);
    src_event <= 7'(1 << b);
    @(posedge hclk);
    src_event <= 7'h0;
    m_st = m_st | (1 << b);
    repeat (8) @(posedge hclk);
  endtask : ev
  // Output read once settled: 0 picks cpu_level, 1 picks irq
  task automatic look(input int which, input logic [31:0] exp);
    @(negedge hclk);
    chk(which == 1 ? {31'h0, irq} : {28'h0, cpu_level}, exp);
    @(posedge hclk);
  endtask : look
  initial begin
    m_lvl = 0; m_ext = 0; m_nest = 0; m_en = 0; m_st = 0; m_mk = 0;
    m_p = '{4, 4, 4, 4};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, then random write/readback, unmapped places included
    foreach (offs[i]) bus(1'b0, offs[i], 32'h0);
    for (int i = 0; i < 24; i++) begin
      n0 = $random(seed) % 9;
      n0 = n0 < 0 ? -n0 : n0;
      bus(1'b1, offs[n0], $random(seed));
      bus(1'b0, offs[n0], 32'h0);
    end
    bus(1'b1, `IPE_OFF_CTL, 32'h8000);
    bus(1'b1, `IPE_OFF_PSW, 32'he0);
    bus(1'b0, `IPE_OFF_PSW, 32'h0);
    bus(1'b1, `IPE_OFF_CTL, 32'h0);
    bus(1'b1, `IPE_OFF_PSW, 32'h0);
    bus(1'b1, `IPE_OFF_STAT, 32'h7f);
    bus(1'b1, `IPE_OFF_EN3, 32'h0);
    bus(1'b1, `IPE_OFF_MASK, 32'h0);
    // Every priority code against a random CPU level, slow and prompt core
    for (int c = 0; c < 8; c++) begin
      lv = $random(seed) & 7;
      dly <= 2'(c);
      bus(1'b1, `IPE_OFF_PR5, 32'(c));
      bus(1'b1, `IPE_OFF_PSW, 32'(lv << 5));
      n0 = acc_n;
      ev(3);
      go = (c != 0 && c > lv) ? 1 : 0;
      chk(32'(acc_n - n0), 32'(go));
      if (go == 1) begin
        chk({26'h0, acc_idx, acc_prio}, 32'((3 << 3) | c));
        m_lvl = c;
        m_st = m_st & ~8;
      end
      look(0, 32'(m_lvl));
      bus(1'b0, `IPE_OFF_STAT, 32'h0);
      bus(1'b1, `IPE_OFF_STAT, 32'h7f);
    end
    // Extension bit lifts the level above every source code
    bus(1'b1, `IPE_OFF_CTL, 32'h8);
    bus(1'b1, `IPE_OFF_PSW, 32'h0);
    bus(1'b1, `IPE_OFF_PR5, 32'h7);
    n0 = acc_n;
    ev(3);
    chk(32'(acc_n - n0), 32'h0);
    look(0, 32'h8);
    bus(1'b1, `IPE_OFF_STAT, 32'h7f);
    bus(1'b1, `IPE_OFF_CTL, 32'h0);
    // Calendar source needs its enable bit
    n0 = acc_n;
    ev(4);
    chk(32'(acc_n - n0), 32'h0);
    bus(1'b1, `IPE_OFF_EN3, 32'h4000);
    repeat (8) @(posedge hclk);
    chk({26'h0, acc_idx, acc_prio}, 32'h24);
    m_lvl = 4;
    m_st = m_st & ~16;
    bus(1'b0, `IPE_OFF_PSW, 32'h0);
    // Interrupt line: raise, mask, unmask, clear
    bus(1'b1, `IPE_OFF_PR5, 32'h0);
    bus(1'b1, `IPE_OFF_MASK, 32'h8);
    ev(3);
    look(1, 32'h1);
    bus(1'b1, `IPE_OFF_MASK, 32'h0);
    look(1, 32'h0);
    bus(1'b1, `IPE_OFF_MASK, 32'h8);
    look(1, 32'h1);
    bus(1'b1, `IPE_OFF_STAT, 32'h8);
    look(1, 32'h0);
    bus(1'b0, `IPE_OFF_STAT, 32'h0);
    stop_test();
  end
endmodule : ipe_top_bench
